// *** common/pif_pkg.sv ***
// constants, field layout and carrier types of the peripheral irq flags
// assumes a classic wishbone slave with one register per aligned word
//
// Notes on behaviour
// - peripheral irqs reach the core only with the peripheral group enable set
// - flags set on their event regardless of own or global enable
// - first enable register: eight rw bits, reset zero, fixed bit order
// - first flag register mirrors enables; receive and transmit flags read only
// - parallel port flag set on host read or write, held until cleared
// - converter flag set on conversion done, zero while none completed
// - receive flag follows receive buffer: one while holding data
// - transmit flag follows transmit buffer: one while empty
// - sync serial flag set on transfer, master condition done, idle bus cond
// - capcomp one flag on capture or compare event, unused in pwm
// - timer two flag set on period match, held until cleared
// - timer one flag set on overflow, held until cleared
// - second enable register bits 6,4,3,0 rw reset zero, rest read zero
// - second flag register same positions, reset zero, rest read zero
// - comparator flag set on comparator input change, held until cleared
// - eeprom flag set when write finishes, zero while write in progress
// - bus collision flag set on collision as i2c master
// - capcomp two flag on capture or compare event, unused in pwm
// - brownout status set by software, cleared by brownout, held if disabled
// - core irq only with global, group enable and an enabled set flag
`default_nettype none

package pif_pkg;

  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_FLAGS_A = 10'h00c;
  localparam logic [9:0] IDX_FLAGS_B = 10'h00d;
  localparam logic [9:0] IDX_ENABLES_A = 10'h08c;
  localparam logic [9:0] IDX_ENABLES_B = 10'h08d;
  localparam logic [9:0] IDX_CORE_CTRL = 10'h00b;
  localparam logic [9:0] IDX_RESET_CAUSE = 10'h08e;

  // first group bit positions
  localparam int BIT_PSP = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_RX = 5;
  localparam int BIT_TX = 4;
  localparam int BIT_SSP = 3;
  localparam int BIT_CAPCOMP_UNIT_ONE = 2;
  localparam int BIT_TIMER_TWO = 1;
  localparam int BIT_TIMER_ONE = 0;

  // second group bit positions
  localparam int BIT_CMP = 6;
  localparam int BIT_EE = 4;
  localparam int BIT_BCL = 3;
  localparam int BIT_CAPCOMP_UNIT_TWO = 0;

  // core control and reset cause positions
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int BIT_BROWNOUT = 0;

  // writable masks and reset values
  localparam logic [7:0] WMASK_FLAGS_A = 8'hcf;
  localparam logic [7:0] WMASK_B = 8'h59;
  localparam logic [7:0] WMASK_CORE = 8'hc0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // event and level inputs from the peripherals
  typedef struct packed {
    logic pspAccess;
    logic adcStart;
    logic adcDone;
    logic rxBufFull;
    logic txBufEmpty;
    logic sspXferDone;
    logic sspCondDone;
    logic sspIdleCond;
    logic ccp1Event;
    logic ccp1Pwm;
    logic tmr2Match;
    logic tmr1Ovf;
    logic cmpChange;
    logic eeStart;
    logic eeDone;
    logic busCollision;
    logic ccp2Event;
    logic ccp2Pwm;
    logic brownout;
  } pif_events_s;

endpackage : pif_pkg

`default_nettype wire

// *** hw/pif_flags.sv ***
// peripheral interrupt enables, flags, core control and irq request
// assumes event inputs synchronous to clock, pulses one cycle wide
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none

module pif_flags
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // peripherals
  input wire pif_events_s events,
  input wire logic brownoutDetectConfig,
  // core
  output logic coreIrq,
  output logic [7:0] flagsA,
  output logic [7:0] flagsB
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] flagsA_q, flagsA_d;
  logic [7:0] flagsB_q, flagsB_d;
  logic [7:0] enA_q, enA_d;
  logic [7:0] enB_q, enB_d;
  logic [7:0] core_q, core_d;
  logic brown_q, brown_d;
  logic req, commit, inRange;
  logic [9:0] idx;
  logic [7:0] wd;
  logic wrFlagsA, wrFlagsB, wrEnA, wrEnB, wrCore, wrCause;

  // request, its index and the commit edge
  assign req = wbCyc & wbStb;
  assign idx = wbAdr[11:2];
  assign inRange = (wbAdr[31:12] == 20'h0_0000) & (wbAdr[1:0] == 2'b00);
  assign commit = req & ack_q & wbWe & wbSel[0] & inRange;
  assign wd = wbDatI[7:0];
  assign wrFlagsA = commit & (idx == IDX_FLAGS_A);
  assign wrFlagsB = commit & (idx == IDX_FLAGS_B);
  assign wrEnA = commit & (idx == IDX_ENABLES_A);
  assign wrEnB = commit & (idx == IDX_ENABLES_B);
  assign wrCore = commit & (idx == IDX_CORE_CTRL);
  assign wrCause = commit & (idx == IDX_RESET_CAUSE);

  ////////////////////////////////////////////////////////////////////////
  // bus answer

  // one ack per request, read data latched with it
  always_comb begin
    ack_d = req & ~ack_q;
    rdat_d = rdat_q;
    if (req & ~ack_q) begin
      rdat_d = RD_ZERO;
      if (inRange) begin
        case (idx)
          IDX_FLAGS_A: rdat_d[7:0] = flagsA_q;
          IDX_FLAGS_B: rdat_d[7:0] = flagsB_q & WMASK_B;
          IDX_ENABLES_A: rdat_d[7:0] = enA_q;
          IDX_ENABLES_B: rdat_d[7:0] = enB_q & WMASK_B;
          IDX_CORE_CTRL: rdat_d[7:0] = core_q & WMASK_CORE;
          IDX_RESET_CAUSE: rdat_d[BIT_BROWNOUT] = brown_q;
          default: rdat_d = RD_ZERO;
        endcase
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rdat_q <= RD_ZERO;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wbAck = ack_q;
  assign wbDatO = rdat_q;

  ////////////////////////////////////////////////////////////////////////
  // enables and core control

  // plain read write storage
  always_comb begin
    enA_d = wrEnA ? wd : enA_q;
    enB_d = wrEnB ? (wd & WMASK_B) : enB_q;
    core_d = wrCore ? (wd & WMASK_CORE) : core_q;
  end

  // enable registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      enA_q <= RST_REG;
      enB_q <= RST_REG;
      core_q <= RST_REG;
    end else begin
      enA_q <= enA_d;
      enB_q <= enB_d;
      core_q <= core_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags, events win over a software clear

  logic [7:0] setA, setB, holdA, holdB;

  // event terms, independent of any enable
  always_comb begin
    setA = RST_REG;
    setA[BIT_PSP] = events.pspAccess;
    setA[BIT_ADC] = events.adcDone;
    setA[BIT_SSP] = events.sspXferDone | events.sspCondDone
                  | events.sspIdleCond;
    setA[BIT_CAPCOMP_UNIT_ONE] = events.ccp1Event & ~events.ccp1Pwm;
    setA[BIT_TIMER_TWO] = events.tmr2Match;
    setA[BIT_TIMER_ONE] = events.tmr1Ovf;
    setB = RST_REG;
    setB[BIT_CMP] = events.cmpChange;
    setB[BIT_EE] = events.eeDone;
    setB[BIT_BCL] = events.busCollision;
    setB[BIT_CAPCOMP_UNIT_TWO] = events.ccp2Event & ~events.ccp2Pwm;
  end

  // next flag values
  always_comb begin
    holdA = wrFlagsA ? (wd & WMASK_FLAGS_A) : (flagsA_q & WMASK_FLAGS_A);
    if (events.adcStart) begin
      holdA[BIT_ADC] = 1'b0;
    end
    flagsA_d = setA | holdA;
    flagsA_d[BIT_RX] = events.rxBufFull;
    flagsA_d[BIT_TX] = events.txBufEmpty;
    holdB = wrFlagsB ? (wd & WMASK_B) : (flagsB_q & WMASK_B);
    if (events.eeStart) begin
      holdB[BIT_EE] = 1'b0;
    end
    flagsB_d = (setB | holdB) & WMASK_B;
  end

  // flag registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flagsA_q <= RST_REG;
      flagsB_q <= RST_REG;
    end else begin
      flagsA_q <= flagsA_d;
      flagsB_q <= flagsB_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // brownout status

  // software sets, a brownout clears unless detection is off
  always_comb begin
    brown_d = brown_q;
    if (wrCause) begin
      brown_d = wd[BIT_BROWNOUT];
    end
    if (events.brownout & brownoutDetectConfig) begin
      brown_d = 1'b0;
    end
  end

  // brownout register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      brown_q <= 1'b0;
    end else begin
      brown_q <= brown_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core request

  logic anyPending;

  // enabled flags gated by group and global enables
  assign anyPending = |(flagsA_q & enA_q) | |(flagsB_q & enB_q & WMASK_B);
  assign coreIrq = core_q[BIT_GIE] & core_q[BIT_PERIPHERAL_GROUP_ENABLE] & anyPending;
  assign flagsA = flagsA_q;
  assign flagsB = flagsB_q;

endmodule // pif_flags

`default_nettype wire

// *** sim/pif_flags_props.sv ***
// assertions on the pif_flags ports
// assumes binding into pif_flags, one clock
`default_nettype none
module pif_flags_props
  import pif_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic wbAck,
  // peripherals and core
  input wire pif_events_s events,
  input wire logic coreIrq,
  input wire logic [7:0] flagsA,
  input wire logic [7:0] flagsB
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // request seen, then one ack pulse
  sequence takeS; wbCyc && wbStb && !wbAck; endsequence
  sequence ackS; wbAck ##1 !wbAck; endsequence
  AST_ACK: assert property (takeS |=> ackS)
    else $error("ack not a single pulse");
  AST_TIMER_ONE: assert property (events.tmr1Ovf |=> flagsA[BIT_TIMER_ONE])
    else $error("timer one flag");
  AST_TIMER_TWO: assert property (events.tmr2Match |=> flagsA[BIT_TIMER_TWO])
    else $error("timer two flag");
  AST_ADC: assert property (events.adcDone |=> flagsA[BIT_ADC])
    else $error("converter flag");
  AST_SSP: assert property (events.sspXferDone || events.sspCondDone
    || events.sspIdleCond |=> flagsA[BIT_SSP])
    else $error("sync serial flag");
  AST_CAPCOMP_UNIT_ONE: assert property (events.ccp1Event && !events.ccp1Pwm
    |=> flagsA[BIT_CAPCOMP_UNIT_ONE])
    else $error("capcomp flag");
  AST_EE: assert property (events.eeDone |=> flagsB[BIT_EE])
    else $error("eeprom flag");
  AST_LEVEL: assert property ($past(rstn) |-> flagsA[5:4] ==
    {$past(events.rxBufFull), $past(events.txBufEmpty)})
    else $error("buffer flags");
  AST_UNUSED: assert property ((flagsB & ~WMASK_B) == 8'h00)
    else $error("unused bits set");
  AST_IRQ: assert property (coreIrq |-> (flagsA | flagsB) != 8'h00)
    else $error("irq without flag");
  AST_STICKY: assert property (flagsA[BIT_TIMER_ONE] && !(wbAck && wbWe)
    |=> flagsA[BIT_TIMER_ONE])
    else $error("flag lost");
endmodule // pif_flags_props
bind pif_flags pif_flags_props i_pif_flags_props(.clock, .rstn, .wbCyc,
  .wbStb, .wbWe, .wbAck, .events, .coreIrq, .flagsA, .flagsB);
`default_nettype wire

// *** sim/pif_periph.sv ***
// peripheral side: turns bench requests into event inputs
// assumes requests change just after a rising edge
`default_nettype none
module pif_periph
  import pif_pkg::*;
(
  // clock
  input wire logic clock,
  // request in, events out
  input wire pif_events_s evReq,
  output var pif_events_s events
);
  timeunit 1ns;
  timeprecision 1ps;
  // one cycle of delay, as a real peripheral
  always_ff @(posedge clock) begin
    events <= evReq;
  end
endmodule // pif_periph
`default_nettype wire

// *** sim/pif_flags_bench.sv ***
// bench for pif_flags: wishbone accesses and event pulses
// assumes pif_periph in front of the event inputs
`default_nettype none
module pif_flags_bench
  import pif_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, wbCyc, wbStb, wbWe, wbAck, coreIrq;
  logic brownoutDetectConfig;
  logic [31:0] wbAdr, wbDatI, wbDatO, rd;
  logic [3:0] wbSel;
  logic [7:0] flagsA, flagsB;
  logic [18:0] evV, lvl;
  pif_events_s events;
  int err_total, checks;
  // event bit positions and expected flag images
  int eb[12] = '{18, 16, 13, 12, 11, 10, 8, 7, 6, 4, 3, 2};
  logic [7:0] ex[12] = '{8'h80, 8'h40, 8'h08, 8'h08, 8'h08, 8'h04,
    8'h02, 8'h01, 8'h40, 8'h10, 8'h08, 8'h01};
  pif_flags i_pif_flags(.clock, .rstn, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatI, .wbDatO, .wbAck, .events, .brownoutDetectConfig,
    .coreIrq, .flagsA, .flagsB);
  pif_periph i_pif_periph(.clock, .evReq(evV | lvl), .events);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [7:0] e);
    checks++;
    if (got !== {24'h00_0000, e}) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, e);
    end
  endtask
  // one bus cycle, with optional event pulse landing on its ack edge
  task automatic acc(input logic [11:0] a, input logic w,
      input logic [7:0] d, input logic [18:0] ev);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {20'h0_0000, a};
    wbDatI <= {24'h00_0000, d};
    evV <= ev;
    @(posedge clock);
    evV <= '0;
    while (wbAck !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20) err_total++;
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    {wbCyc, wbStb, wbWe, rstn} = 4'h0;
    {wbAdr, wbDatI} = '0;
    {evV, lvl} = '0;
    wbSel = 4'hf;
    brownoutDetectConfig = 1'b1;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (eb[i]) begin
      acc(12'h030 + 12'(i % 2) * 12'h004 + 12'(i % 4 / 2) * 12'h200, 0,
        8'h00, '0);
      if (i < 4) chk(rd, 8'h00);
    end
    acc(12'h100, 0, 8'h00, '0);
    chk(rd, 8'h00);
    acc(12'h234, 1, 8'hff, '0);
    acc(12'h234, 0, 8'h00, '0);
    chk(rd, 8'h59);
    acc(12'h034, 1, 8'hff, '0);
    acc(12'h034, 0, 8'h00, '0);
    chk(rd, 8'h59);
    acc(12'h030, 1, 8'hff, '0);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'hcf);
    acc(12'h030, 1, 8'h00, '0);
    acc(12'h034, 1, 8'h00, '0);
    acc(12'h230, 1, 8'hff, '0);
    acc(12'h230, 0, 8'h00, '0);
    chk(rd, 8'hff);
    $display("test registers done");
    acc(12'h02c, 1, 8'h80, 19'h0_0080);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h01);
    chk({31'h0, coreIrq}, 8'h00);
    acc(12'h02c, 1, 8'hc0, '0);
    chk({31'h0, coreIrq}, 8'h01);
    acc(12'h030, 1, 8'h00, 19'h0_0080);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h01);
    acc(12'h030, 1, 8'h00, '0);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h00);
    $display("test enables done");
    foreach (eb[i]) begin
      acc(12'h100, 0, 8'h00, 19'h0_0001 << eb[i]);
      acc(i < 8 ? 12'h030 : 12'h034, 0, 8'h00, '0);
      chk(rd, ex[i]);
      chk({31'h0, coreIrq}, 8'h01);
      acc(i < 8 ? 12'h030 : 12'h034, 1, 8'h00, '0);
      chk({31'h0, coreIrq}, 8'h00);
    end
    acc(12'h100, 0, 8'h00, 19'h0_0010);
    acc(12'h100, 0, 8'h00, 19'h0_0020);
    acc(12'h034, 0, 8'h00, '0);
    chk(rd, 8'h00);
    lvl <= 19'h0_0200;
    acc(12'h100, 0, 8'h00, 19'h0_0400);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h00);
    lvl <= 19'h0_8000;
    acc(12'h030, 1, 8'h00, '0);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h20);
    lvl <= 19'h0_4000;
    acc(12'h030, 1, 8'h20, '0);
    acc(12'h030, 0, 8'h00, '0);
    chk(rd, 8'h10);
    $display("test events done");
    for (int c = 1; c >= 0; c--) begin
      brownoutDetectConfig <= c[0];
      acc(12'h238, 1, 8'h01, '0);
      acc(12'h100, 0, 8'h00, 19'h0_0001);
      acc(12'h238, 0, 8'h00, '0);
      chk(rd, c[0] ? 8'h00 : 8'h01);
    end
    $display("test brownout done");
    end_sim();
  end
endmodule // pif_flags_bench
`default_nettype wire
